//--- design/epa_regs.svh
// Register indices, field positions, reset values and timing counts.
`ifndef EPA_REGS_SVH
`define EPA_REGS_SVH
`define EPA_IDX_BCTL 5'h00
`define EPA_IDX_STAT 5'h01
`define EPA_IDX_ID1 5'h02
`define EPA_IDX_ID2 5'h03
`define EPA_IDX_ADV 5'h04
`define EPA_IDX_LPA 5'h05
`define EPA_IDX_EXP 5'h06
`define EPA_IDX_MFC 5'h10
`define EPA_IDX_RCTL 5'h11
`define EPA_BCTL_RST 15
`define EPA_BCTL_LOOP 14
`define EPA_BCTL_SPD 13
`define EPA_BCTL_ANEN 12
`define EPA_BCTL_ISO 10
`define EPA_BCTL_RSTAN 9
`define EPA_BCTL_DUP 8
`define EPA_BCTL_COLT 7
`define EPA_BCTL_RESET 16'h3100
`define EPA_ADV_RESET 16'h05e1
`define EPA_ADV_SYM 10
`define EPA_ADV_ASYM 11
`define EPA_STAT_BASE 16'h780d
`define EPA_STAT_ANC 5
`define EPA_EXP_LPAN 0
`define EPA_EXP_PGR 1
`define EPA_MFC_TX 0
`define EPA_MFC_RX 1
`define EPA_MFC_SEL 2
`define EPA_RCTL_VRST 1
`define EPA_UNMAPPED 16'hffff
`define EPA_CLK_NS 50
`define EPA_SRST_NS 102000
`define EPA_SRST_CYC (`EPA_SRST_NS / `EPA_CLK_NS)
`define EPA_MD_HDR 6'h0c
`define EPA_MD_TA 6'h0d
`define EPA_MD_LAST 6'h1e
`endif

//--- design/epa_pkg.sv
// Types shared by the emulated negotiation block.
package epa_pkg;
  typedef enum logic [4:0] {
    ST_START = 5'b00001,
    ST_CPL = 5'b00010,
    ST_PGR = 5'b00100,
    ST_RES = 5'b01000,
    ST_DONE = 5'b10000
  } epa_neg_e;
  typedef struct packed {
    logic speed100;
    logic full;
    logic tx_fc;
    logic rx_fc;
  } epa_mode_s;
  typedef struct packed {
    logic dup_pin;
    logic dup_pol;
    logic spd;
  } epa_strap_s;
endpackage : epa_pkg

//--- design/epa_top.sv
// Emulated single-port management and negotiation block.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "epa_regs.svh"
module epa_top #(
  parameter logic [4:0] PHY_ADDR = 5'h00,
  parameter logic [15:0] ID1 = 16'h1234,
  parameter logic [15:0] ID2 = 16'h5670,
  parameter int SRST_CYC = `EPA_SRST_CYC
) (
  // Clock, reset and freeze.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Pins and straps.
  input wire logic external_reset_pin_n_i,
  input wire logic port_duplex_input_pin_i,
  input wire logic dup_pol_strap_i,
  input wire logic speed_strap_i,
  input wire logic mac_mode_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n_o,
  // Chip events.
  input wire logic dig_rst_i,
  input wire logic reload_i,
  // Register port.
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Switch port settings.
  output epa_pkg::epa_mode_s mode_o,
  output logic neg_done_o,
  output logic loopback_o,
  output logic isolate_o,
  output logic coll_test_o
);
  // The ID values are arbitrary.
  localparam logic [11:0] SRST_W = 12'(SRST_CYC);

  logic [6:0] s1_q, s2_q;
  logic mdc_d_q, ext_rst, mdio_bit, mdc_rise, mac, anc_q, res_spd_q, res_full_q;
  epa_pkg::epa_strap_s strap_q;
  logic [15:0] emu_basic_control_reg_q, emu_advertisement_reg_q, emu_partner_ability_reg_q;
  logic [15:0] manual_flow_control_reg_q, chip_reset_control_reg_q, wr_dat;
  logic [1:0] exp_q;
  logic [11:0] srst_cnt_q;
  epa_pkg::epa_neg_e neg_q;
  logic blk_rst, hw_rst, an_en, wr_en, rstan, md_act_q, md_prev_q, md_rd_q, md_wr_q, md_we_q;
  logic [4:0] wr_idx, md_reg_q;
  logic [3:0] partner, common;
  logic [5:0] md_cnt_q;
  logic [15:0] md_sr_q, md_tx_q, md_wdat_q;
  logic [12:0] md_hdr;
  epa_pkg::epa_mode_s mode_d;

  // Best shared ability as {speed100, full}; bits are 100F,100H,10F,10H.
  function automatic logic [1:0] best_shared_ability(input logic [3:0] c);
    logic [1:0] r;
    r = 2'b00;
    if (c[3]) begin
      r = 2'b11;
    end else if (c[2]) begin
      r = 2'b10;
    end else if (c[1]) begin
      r = 2'b01;
    end
    return r;
  endfunction : best_shared_ability

  // Read multiplexer shared by the register port and the serial path.
  function automatic logic [15:0] rd_mux(input logic [4:0] idx);
    logic [15:0] r;
    r = `EPA_UNMAPPED;
    case (idx)
      `EPA_IDX_BCTL: r = emu_basic_control_reg_q;
      `EPA_IDX_STAT: r = `EPA_STAT_BASE | (16'(anc_q) << `EPA_STAT_ANC);
      `EPA_IDX_ID1: r = ID1;
      `EPA_IDX_ID2: r = ID2;
      `EPA_IDX_ADV: r = emu_advertisement_reg_q;
      `EPA_IDX_LPA: r = emu_partner_ability_reg_q;
      `EPA_IDX_EXP: r = {14'h0000, exp_q};
      `EPA_IDX_MFC: r = manual_flow_control_reg_q;
      `EPA_IDX_RCTL: r = chip_reset_control_reg_q;
      default: r = `EPA_UNMAPPED;
    endcase
    return r;
  endfunction : rd_mux

  // Synchronisers run through reset, so the straps are valid while it is held.
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      s1_q <= {mdc_i, mdio_i, mac_mode_i, speed_strap_i,
               dup_pol_strap_i, port_duplex_input_pin_i,
               external_reset_pin_n_i};
      s2_q <= s1_q;
      mdc_d_q <= s2_q[6];
    end
  end

  assign ext_rst = !s2_q[0];
  assign mdio_bit = s2_q[5];
  assign mac = s2_q[4];
  assign mdc_rise = s2_q[6] && !mdc_d_q;
  assign hw_rst = rst_i || ext_rst;
  assign blk_rst = hw_rst || dig_rst_i || reload_i ||
                   chip_reset_control_reg_q[`EPA_RCTL_VRST] ||
                   emu_basic_control_reg_q[`EPA_BCTL_RST];
  assign an_en = emu_basic_control_reg_q[`EPA_BCTL_ANEN];

  // Straps are caught only at hardware reset or reload.
  always_ff @(posedge clk_i) begin
    if (ce_i && (hw_rst || reload_i)) begin
      strap_q <= {s2_q[1], s2_q[2], s2_q[3]};
    end
  end

  // Write source: the register port wins over a serial write.
  always_comb begin
    wr_en = reg_wr_i || md_we_q;
    wr_idx = reg_wr_i ? reg_addr_i : md_reg_q;
    wr_dat = reg_wr_i ? reg_wdata_i : md_wdat_q;
  end
  assign rstan = wr_en && wr_idx == `EPA_IDX_BCTL && wr_dat[`EPA_BCTL_RSTAN];

  // Basic control; the reset bit holds the block in reset one cycle.
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      emu_basic_control_reg_q <= `EPA_BCTL_RESET;
    end else if (ce_i && wr_en && wr_idx == `EPA_IDX_BCTL) begin
      emu_basic_control_reg_q <= wr_dat & ~(16'h0001 << `EPA_BCTL_RSTAN);
    end
  end
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      emu_advertisement_reg_q <= `EPA_ADV_RESET;
    end else if (ce_i && wr_en && wr_idx == `EPA_IDX_ADV) begin
      emu_advertisement_reg_q <= wr_dat & 16'h0dff;
    end
  end
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      manual_flow_control_reg_q <= 16'h0000;
    end else if (ce_i) begin
      manual_flow_control_reg_q[15:3] <= {10'h000, mode_d.full,
                                          mode_d.tx_fc, mode_d.rx_fc};
      if (wr_en && wr_idx == `EPA_IDX_MFC) begin
        manual_flow_control_reg_q[2:0] <= wr_dat[2:0];
      end
    end
  end

  // Chip-level reset bit clears itself after its count.
  always_ff @(posedge clk_i) begin
    if (hw_rst) begin
      chip_reset_control_reg_q <= 16'h0000;
      srst_cnt_q <= 12'h000;
    end else if (ce_i) begin
      if (chip_reset_control_reg_q[`EPA_RCTL_VRST]) begin
        srst_cnt_q <= srst_cnt_q + 12'h001;
        if (srst_cnt_q == SRST_W - 12'h001) begin
          chip_reset_control_reg_q <= 16'h0000;
        end
      end else if (wr_en && wr_idx == `EPA_IDX_RCTL) begin
        chip_reset_control_reg_q <= wr_dat & 16'h0002;
        srst_cnt_q <= 12'h000;
      end
    end
  end
  always_comb begin
    partner = {strap_q.spd && strap_q.dup_pin == strap_q.dup_pol,
               strap_q.spd,
               strap_q.dup_pin == strap_q.dup_pol,
               1'b1};
    common = emu_advertisement_reg_q[8:5] & partner;
  end
  always_ff @(posedge clk_i) begin
    if (blk_rst || (ce_i && rstan)) begin
      neg_q <= epa_pkg::ST_START;
      anc_q <= 1'b0;
      exp_q <= 2'b00;
      emu_partner_ability_reg_q <= 16'h0000;
      res_spd_q <= 1'b0;
      res_full_q <= 1'b0;
    end else if (ce_i) begin
      case (neg_q)
        epa_pkg::ST_START: begin
          if (an_en) begin
            neg_q <= epa_pkg::ST_CPL;
          end
        end
        epa_pkg::ST_CPL: begin
          anc_q <= 1'b1;
          neg_q <= epa_pkg::ST_PGR;
        end
        epa_pkg::ST_PGR: begin
          exp_q[`EPA_EXP_PGR] <= 1'b1;
          neg_q <= epa_pkg::ST_RES;
        end
        epa_pkg::ST_RES: begin
          neg_q <= epa_pkg::ST_DONE;
          if (|common) begin
            exp_q[`EPA_EXP_LPAN] <= 1'b1;
            {res_spd_q, res_full_q} <= best_shared_ability(common);
            emu_partner_ability_reg_q <= {4'h0,
              emu_advertisement_reg_q[11:10], 1'b0, partner,
              5'h01};
          end else begin
            exp_q[`EPA_EXP_LPAN] <= 1'b0;
            res_spd_q <= strap_q.spd;
            res_full_q <= 1'b0;
            emu_partner_ability_reg_q <= {4'h0,
              emu_advertisement_reg_q[11:10], 1'b0,
              1'b0, strap_q.spd, 1'b0, !strap_q.spd, 5'h01};
          end
        end
        epa_pkg::ST_DONE: begin
          neg_q <= epa_pkg::ST_DONE;
        end
        default: begin
          neg_q <= epa_pkg::ST_START;
        end
      endcase
    end
  end
  always_comb begin
    mode_d.speed100 = an_en ? res_spd_q
                    : emu_basic_control_reg_q[`EPA_BCTL_SPD];
    if (mac) begin
      mode_d.full = an_en ? (s2_q[1] == s2_q[2])
                  : emu_basic_control_reg_q[`EPA_BCTL_DUP];
    end else begin
      mode_d.full = an_en ? res_full_q
                  : emu_basic_control_reg_q[`EPA_BCTL_DUP];
    end
    if (!an_en || manual_flow_control_reg_q[`EPA_MFC_SEL]) begin
      mode_d.tx_fc = manual_flow_control_reg_q[`EPA_MFC_TX];
      mode_d.rx_fc = manual_flow_control_reg_q[`EPA_MFC_RX];
    end else begin
      mode_d.tx_fc = mode_d.full &&
                     emu_partner_ability_reg_q[`EPA_ADV_SYM];
      mode_d.rx_fc = mode_d.full &&
                     (emu_partner_ability_reg_q[`EPA_ADV_SYM] ||
                      emu_partner_ability_reg_q[`EPA_ADV_ASYM]);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_o <= '0;
      neg_done_o <= 1'b0;
      loopback_o <= 1'b0;
      isolate_o <= 1'b0;
      coll_test_o <= 1'b0;
    end else if (ce_i) begin
      mode_o <= mode_d;
      neg_done_o <= anc_q;
      loopback_o <= emu_basic_control_reg_q[`EPA_BCTL_LOOP];
      isolate_o <= emu_basic_control_reg_q[`EPA_BCTL_ISO];
      coll_test_o <= emu_basic_control_reg_q[`EPA_BCTL_COLT];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (ce_i && reg_rd_i) begin
      reg_rdata_o <= rd_mux(reg_addr_i);
    end
  end

  // Serial management frame receiver and responder.
  assign md_hdr = {md_sr_q[11:0], mdio_bit};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      md_act_q <= 1'b0;
      md_prev_q <= 1'b0;
      md_cnt_q <= 6'h00;
      md_sr_q <= 16'h0000;
      md_rd_q <= 1'b0;
      md_wr_q <= 1'b0;
      md_reg_q <= 5'h00;
      md_tx_q <= 16'h0000;
      md_we_q <= 1'b0;
      md_wdat_q <= 16'h0000;
      mdio_o <= 1'b1;
      mdio_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      md_we_q <= 1'b0;
      if (mdc_rise) begin
        md_prev_q <= mdio_bit;
        if (!md_act_q) begin
          if (md_prev_q && !mdio_bit) begin
            md_act_q <= 1'b1;
            md_cnt_q <= 6'h00;
          end
        end else begin
          md_cnt_q <= md_cnt_q + 6'h01;
          md_sr_q <= {md_sr_q[14:0], mdio_bit};
          if (md_cnt_q == `EPA_MD_HDR) begin
            md_reg_q <= md_hdr[4:0];
            md_rd_q <= md_hdr[11:10] == 2'b10 && md_hdr[9:5] == PHY_ADDR &&
                       !mac && md_hdr[4:0] <= `EPA_IDX_EXP;
            md_wr_q <= md_hdr[11:10] == 2'b01 && md_hdr[9:5] == PHY_ADDR &&
                       !mac && md_hdr[4:0] <= `EPA_IDX_EXP;
            if (!md_hdr[12]) begin
              md_act_q <= 1'b0;
            end
          end
          if (md_cnt_q == `EPA_MD_TA && md_rd_q) begin
            mdio_o <= 1'b0;
            mdio_oe_n_o <= 1'b0;
            md_tx_q <= rd_mux(md_reg_q);
          end
          if (md_cnt_q > `EPA_MD_TA && md_cnt_q < `EPA_MD_LAST && md_rd_q) begin
            mdio_o <= md_tx_q[15];
            md_tx_q <= {md_tx_q[14:0], 1'b0};
          end
          if (md_cnt_q == `EPA_MD_LAST) begin
            md_act_q <= 1'b0;
            md_prev_q <= 1'b0;
            mdio_o <= 1'b1;
            mdio_oe_n_o <= 1'b1;
            md_rd_q <= 1'b0;
            md_wr_q <= 1'b0;
            md_we_q <= md_wr_q;
            md_wdat_q <= {md_sr_q[14:0], mdio_bit};
          end
        end
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || !ce_i);

  AST_RESTART: assert property (rstan && !blk_rst |=> neg_q == epa_pkg::ST_START)
    else $error("restart did not return to start");
  AST_ORDER: assert property (neg_q == epa_pkg::ST_CPL && !blk_rst && !rstan
    |=> anc_q && !exp_q[`EPA_EXP_PGR] ##1 exp_q[`EPA_EXP_PGR] || blk_rst)
    else $error("negotiation steps out of order");
  AST_FINISH: assert property (neg_q == epa_pkg::ST_CPL && !blk_rst && !rstan
    ##1 !blk_rst && !rstan ##1 !blk_rst && !rstan
    |=> neg_q == epa_pkg::ST_DONE)
    else $error("negotiation did not finish in three cycles");
  AST_BEST: assert property (neg_q == epa_pkg::ST_RES && !blk_rst && !rstan && common[3]
    |=> res_spd_q && res_full_q)
    else $error("best mode not chosen");
  AST_ADV_RST: assert property (blk_rst |=> emu_advertisement_reg_q[8:5] == 4'hf)
    else $error("advertisement reset value wrong");
  AST_HOLD: assert property (neg_q == epa_pkg::ST_DONE && !blk_rst && !rstan
    |=> $stable({res_spd_q, res_full_q}))
    else $error("result changed without rerun");
  AST_PARALLEL: assert property (neg_q == epa_pkg::ST_RES && !blk_rst && !rstan && common == 4'h0
    |=> !exp_q[`EPA_EXP_LPAN] && !res_full_q && $onehot(emu_partner_ability_reg_q[8:5]))
    else $error("parallel detect result wrong");
  AST_FORCE: assert property (!an_en ##1 !an_en |-> mode_o.speed100 == $past(
    emu_basic_control_reg_q[`EPA_BCTL_SPD]))
    else $error("forced speed not applied");
  AST_MACDUP: assert property (mac && an_en |=> mode_o.full == $past(s2_q[1] == s2_q[2]))
    else $error("mac mode duplex not tracking");
  AST_NOMDIO: assert property (mac && mdc_rise && md_act_q && md_cnt_q == `EPA_MD_HDR
    |=> !md_rd_q && !md_wr_q)
    else $error("serial access accepted in mac mode");
  AST_SRST: assert property ($rose(chip_reset_control_reg_q[`EPA_RCTL_VRST])
    |-> blk_rst [*8])
    else $error("chip reset bit did not hold the block");
endmodule : epa_top

//--- dv/epa_mdio_master.sv
// Management master model that drives clause 22 frames on the serial link.
`timescale 1ns/1ns
module epa_mdio_master (
  // Clock.
  input wire logic clk_i,
  // Serial link.
  input wire logic dut_mdio_i,
  input wire logic dut_mdio_oe_n_i,
  output logic mdc_o,
  output logic line_o
);
  logic m_en;
  logic m_val;
  // The line has a pull-up, so a released line reads high.
  assign line_o = (dut_mdio_oe_n_i ? 1'b1 : dut_mdio_i) & (m_en ? m_val : 1'b1);
  initial begin
    mdc_o = 1'b0;
    m_en = 1'b0;
    m_val = 1'b1;
  end
  // One frame of 64 bit slots at 8 system cycles each; the clock stands still after it.
  task automatic frame(input logic rd, input logic [4:0] idx, input logic [15:0] wd,
                       output logic [15:0] rdv);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'b01, (rd ? 2'b10 : 2'b01), 5'h00, idx, 2'b10, wd};
    rdv = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      @(posedge clk_i);
      mdc_o <= 1'b0;
      m_en <= !(rd && i < 18);
      m_val <= bits[i];
      repeat (4) @(posedge clk_i);
      rdv = {rdv[14:0], line_o};
      mdc_o <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
    @(posedge clk_i);
    mdc_o <= 1'b0;
    m_en <= 1'b0;
  endtask : frame
endmodule : epa_mdio_master

//--- dv/tb_top.sv
// Self-checking testbench for the emulated negotiation block.
`timescale 1ns/1ns
`include "epa_regs.svh"
module tb_top;
  localparam int SRST = 16;
  logic clk_i;
  logic rst_i;
  logic ext_rst_n;
  logic dup_pin;
  logic dup_pol;
  logic spd_strap;
  logic mac_mode;
  logic dig_rst;
  logic reload;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  epa_pkg::epa_mode_s mode;
  logic neg_done;
  logic loopback;
  logic isolate;
  logic coll_test;
  logic mdc;
  logic mdio_line;
  logic dut_mdio;
  logic dut_mdio_oe_n;
  logic [15:0] rv;
  int n_mismatch;
  int n_checks;

  epa_top #(.SRST_CYC(SRST)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .external_reset_pin_n_i(ext_rst_n),
    .port_duplex_input_pin_i(dup_pin), .dup_pol_strap_i(dup_pol),
    .speed_strap_i(spd_strap), .mac_mode_i(mac_mode), .mdc_i(mdc), .mdio_i(mdio_line),
    .mdio_o(dut_mdio), .mdio_oe_n_o(dut_mdio_oe_n), .dig_rst_i(dig_rst),
    .reload_i(reload), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .mode_o(mode), .neg_done_o(neg_done),
    .loopback_o(loopback), .isolate_o(isolate), .coll_test_o(coll_test)
  );
  epa_mdio_master u_mdio (
    .clk_i(clk_i), .dut_mdio_i(dut_mdio), .dut_mdio_oe_n_i(dut_mdio_oe_n),
    .mdc_o(mdc), .line_o(mdio_line)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_mode(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: mode %h expected %h", $time, got, exp);
    end
  endtask : chk_mode
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_rd
  task automatic restart;
    reg_wr(`EPA_IDX_BCTL, 16'h1200);
    tick(10);
  endtask : restart
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic t_defaults;
    chk_reg({15'h0000, neg_done}, 16'h0001);
    reg_rd(`EPA_IDX_BCTL, rv);
    chk_reg(rv, 16'h3100);
    reg_rd(`EPA_IDX_ADV, rv);
    chk_reg(rv, 16'h05e1);
    reg_rd(`EPA_IDX_STAT, rv);
    chk_reg(rv, 16'h782d);
    reg_rd(`EPA_IDX_EXP, rv);
    chk_reg(rv & 16'h0003, 16'h0003);
    reg_rd(`EPA_IDX_LPA, rv);
    chk_reg(rv & 16'hafe0, 16'h05e0);
    reg_rd(5'h1f, rv);
    chk_reg(rv, 16'hffff);
    chk_mode(mode, 4'hf);
  endtask : t_defaults

  task automatic t_resolve;
    logic [15:0] adv [6];
    logic [3:0] exp [6];
    adv = '{16'h0420, 16'h0440, 16'h04c0, 16'h0560, 16'h0c80, 16'h0940};
    exp = '{4'h0, 4'h7, 4'h8, 4'hf, 4'h8, 4'hd};
    reg_wr(`EPA_IDX_ADV, 16'h0420);
    tick(10);
    chk_mode(mode, 4'hf);
    for (int i = 0; i < 6; i++) begin
      reg_wr(`EPA_IDX_ADV, adv[i]);
      restart();
      chk_mode(mode, exp[i]);
    end
  endtask : t_resolve

  task automatic t_parallel;
    reg_wr(`EPA_IDX_ADV, 16'h0400);
    restart();
    chk_mode(mode, 4'h8);
    reg_rd(`EPA_IDX_EXP, rv);
    chk_reg(rv & 16'h0003, 16'h0002);
    reg_rd(`EPA_IDX_LPA, rv);
    chk_reg(rv & 16'h01e0, 16'h0080);
    reg_wr(`EPA_IDX_ADV, 16'h05e1);
    restart();
  endtask : t_parallel

  task automatic t_forced;
    reg_wr(`EPA_IDX_BCTL, 16'h4180);
    tick(4);
    chk_mode(mode, 4'h4);
    chk_reg({13'h0000, loopback, isolate, coll_test}, 16'h0005);
    reg_wr(`EPA_IDX_MFC, 16'h0003);
    tick(4);
    chk_mode(mode, 4'h7);
    reg_rd(`EPA_IDX_MFC, rv);
    chk_reg(rv, 16'h003b);
    reg_rd(`EPA_IDX_ADV, rv);
    chk_reg(rv, 16'h05e1);
    reg_wr(`EPA_IDX_MFC, 16'h0000);
    restart();
  endtask : t_forced

  task automatic t_mac;
    mac_mode <= 1'b1;
    dup_pin <= 1'b0;
    tick(8);
    chk_reg({15'h0000, mode.full}, 16'h0000);
    dup_pin <= 1'b1;
    tick(8);
    chk_reg({15'h0000, mode.full}, 16'h0001);
    u_mdio.frame(1'b1, `EPA_IDX_BCTL, 16'h0000, rv);
    chk_reg(rv, 16'hffff);
    reg_wr(`EPA_IDX_BCTL, 16'h0100);
    dup_pin <= 1'b0;
    tick(8);
    chk_reg({15'h0000, mode.full}, 16'h0001);
    reg_wr(`EPA_IDX_BCTL, 16'h1000);
    tick(8);
    chk_reg({15'h0000, mode.full}, 16'h0000);
    reg_wr(`EPA_IDX_MFC, 16'h0007);
    tick(4);
    chk_mode(mode, 4'hb);
    mac_mode <= 1'b0;
    restart();
    chk_mode(mode, 4'hf);
    dup_pin <= 1'b1;
  endtask : t_mac

  task automatic t_mdio;
    u_mdio.frame(1'b1, `EPA_IDX_BCTL, 16'h0000, rv);
    chk_reg(rv, 16'h1000);
    u_mdio.frame(1'b0, `EPA_IDX_ADV, 16'h0441, rv);
    tick(4);
    reg_rd(`EPA_IDX_ADV, rv);
    chk_reg(rv, 16'h0441);
    u_mdio.frame(1'b1, `EPA_IDX_STAT, 16'h0000, rv);
    chk_reg(rv, 16'h782d);
    u_mdio.frame(1'b1, 5'h07, 16'h0000, rv);
    chk_reg(rv, 16'hffff);
  endtask : t_mdio

  task automatic t_resets;
    reg_wr(`EPA_IDX_ADV, 16'h0421);
    reg_wr(`EPA_IDX_BCTL, 16'h8000);
    tick(8);
    reg_rd(`EPA_IDX_BCTL, rv);
    chk_reg(rv, 16'h3100);
    reg_rd(`EPA_IDX_ADV, rv);
    chk_reg(rv, 16'h05e1);
    reg_wr(`EPA_IDX_ADV, 16'h0421);
    reg_wr(`EPA_IDX_RCTL, 16'h0002);
    tick(2);
    reg_rd(`EPA_IDX_RCTL, rv);
    chk_reg(rv, 16'h0002);
    tick(SRST + 4);
    reg_rd(`EPA_IDX_RCTL, rv);
    chk_reg(rv, 16'h0000);
    reg_rd(`EPA_IDX_ADV, rv);
    chk_reg(rv, 16'h05e1);
    for (int i = 0; i < 3; i++) begin
      reg_wr(`EPA_IDX_ADV, 16'h0421);
      dig_rst <= (i == 0);
      reload <= (i == 1);
      ext_rst_n <= (i != 2);
      tick(4);
      dig_rst <= 1'b0;
      reload <= 1'b0;
      ext_rst_n <= 1'b1;
      tick(12);
      reg_rd(`EPA_IDX_ADV, rv);
      chk_reg(rv, 16'h05e1);
      chk_reg({15'h0000, neg_done}, 16'h0001);
    end
  endtask : t_resets

  initial begin
    n_mismatch = 0;
    n_checks = 0;
    rst_i = 1'b1;
    ext_rst_n = 1'b1;
    dup_pin = 1'b1;
    dup_pol = 1'b1;
    spd_strap = 1'b1;
    mac_mode = 1'b0;
    dig_rst = 1'b0;
    reload = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    tick(10);
    rst_i <= 1'b0;
    tick(10);
    t_defaults();
    t_resolve();
    t_parallel();
    t_forced();
    t_mac();
    t_mdio();
    t_resets();
    print_verdict();
  end

  initial begin
    #2000000;
    n_mismatch++;
    print_verdict();
  end
endmodule : tb_top
